// ### inc/fcq_pkg.sv
// Function
// - Write strobe stores word in next slot.
// - Words leave in the order written.
// - Full flag high when no slot remains.
// - Empty flag high when queue holds nothing.
// - Fill fraction unsigned, binary point above top.
// - Lookahead shows oldest word without a read.
// - Output registers add exactly one cycle latency.
// - Output registers reset data to chosen value.
// - Depth is a parameter, 16K to 4M.
// - Reset delayed by configurable stages, default one.
// - Second family: disabled 20 cycles after reset.
// - Count port gives words currently held.
// - Near-empty and near-full flags are optional.
// - First family without reset: wait 8 cycles.
// - Reset held at least three, five recommended.
// - First family: strobes low 30 after release.
// - Second family: reset pulse of one cycle minimum.
// - Third family: strobe only while not busy.
`default_nettype none
package fcq_pkg;
   localparam int WIDTH_DFLT = 16;
   localparam int DEPTH_DFLT = 16384;
   localparam int PREC_DFLT = 4;
   localparam int RST_LAT_DFLT = 1;
   localparam int AE_LEVEL_DFLT = 4;
   localparam int AF_LEVEL_DFLT = 4;
   localparam int DISABLE_CYC = 20;
   localparam int START_WAIT_CYC = 8;
   localparam int RST_HOLD_MIN = 3;
   localparam int RST_HOLD_CYC = 5;
   localparam int QUIET_CYC = 30;
   localparam int GATE_W = 6;

   typedef enum {
      FCQ_FAMILY_FIRST,
      FCQ_FAMILY_SECOND,
      FCQ_FAMILY_THIRD
   } fcq_family_type;

   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] COUNT_OFS = 8'h08;
   localparam logic [7:0] DATA_OFS = 8'h0c;
   localparam logic [7:0] FILL_OFS = 8'h10;

   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RST_BIT = 1;
   localparam logic CTRL_EN_RST = 1'b0;

   localparam int ST_FULL_BIT = 0;
   localparam int ST_EMPTY_BIT = 1;
   localparam int ST_NE_BIT = 2;
   localparam int ST_NF_BIT = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int ST_GATE_BIT = 5;
endpackage
`default_nettype wire

// ### inc/fcq_link.sv
`default_nettype none
interface fcq_link #(
   parameter int WIDTH = fcq_pkg::WIDTH_DFLT,
   parameter int DEPTH = fcq_pkg::DEPTH_DFLT,
   parameter int PREC = fcq_pkg::PREC_DFLT
);
   localparam int CW = $clog2(DEPTH) + 2;
   logic wr_strobe;
   logic [WIDTH-1:0] wr_data;
   logic wr_ready;
   logic fetch_strobe;
   logic [WIDTH-1:0] rd_data;
   logic rd_valid;
   logic full_flag;
   logic empty_flag;
   logic near_empty_flag;
   logic near_full_flag;
   logic [PREC-1:0] fill_fraction;
   logic [CW-1:0] word_count;
   logic reset_req;
   logic enable;
   logic busy_flag;

   modport dev (
      input wr_strobe, wr_data, fetch_strobe, reset_req, enable,
      output wr_ready, rd_data, rd_valid, full_flag, empty_flag,
      output near_empty_flag, near_full_flag, fill_fraction, word_count,
      output busy_flag
   );
   modport host (
      output wr_strobe, wr_data, fetch_strobe, reset_req, enable,
      input wr_ready, rd_data, rd_valid, full_flag, empty_flag,
      input near_empty_flag, near_full_flag, fill_fraction, word_count,
      input busy_flag
   );
endinterface
`default_nettype wire

// ### src/fcq_queue.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`default_nettype none
module fcq_queue #(
   parameter int WIDTH = fcq_pkg::WIDTH_DFLT,
   parameter int DEPTH = fcq_pkg::DEPTH_DFLT,
   parameter int PREC = fcq_pkg::PREC_DFLT,
   parameter bit LOOKAHEAD = 1'b0,
   parameter bit EMB_REG = 1'b0,
   parameter int RST_LAT = fcq_pkg::RST_LAT_DFLT,
   parameter fcq_pkg::fcq_family_type FAMILY = fcq_pkg::FCQ_FAMILY_FIRST,
   parameter bit HAS_AE = 1'b1,
   parameter bit HAS_AF = 1'b1,
   parameter int AE_LEVEL = fcq_pkg::AE_LEVEL_DFLT,
   parameter int AF_LEVEL = fcq_pkg::AF_LEVEL_DFLT,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic CLK,
   input wire logic NRST,
   fcq_link.dev LNK
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 2;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [4:0] DIS_C = 5'(fcq_pkg::DISABLE_CYC);

   // The array is sized by DEPTH; the pointers wrap on a power of two.
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic [RST_LAT-1:0] rpipe_reg;
   logic [4:0] dis_reg;
   logic [WIDTH-1:0] st_data_reg;
   logic st_v_reg;
   logic st_v_next;
   logic [WIDTH-1:0] out_data_reg;
   logic out_v_reg;
   logic srst;
   logic busy;
   logic go;
   logic mem_full;
   logic mem_empty;
   logic push;
   logic pop_out;
   logic mem_rd;
   logic [CW-1:0] total;

   function automatic logic [PREC-1:0] frac_of(input logic [CW-1:0] n);
      logic [CW+PREC-1:0] s;
      s = {n, PREC'(0)} / (CW + PREC)'(DEPTH);
      if (s > (CW + PREC)'({PREC{1'b1}})) begin
         s = (CW + PREC)'({PREC{1'b1}});
      end
      return s[PREC-1:0];
   endfunction

   assign srst = rpipe_reg[RST_LAT-1];
   assign busy = srst || (dis_reg != 5'h00);
   // Enable low or reset in progress freezes both sides of the queue.
   assign go = LNK.enable && !busy;
   assign mem_full = (cnt_reg == DEPTH_C);
   assign mem_empty = (cnt_reg == CW'(0));
   assign push = LNK.wr_strobe && !mem_full && go;

   always_comb begin
      if (LOOKAHEAD) begin
         // The head stage refills on its own, so no read is needed.
         pop_out = LNK.fetch_strobe && LNK.rd_valid && go;
         mem_rd = !mem_empty && go && (!st_v_reg || pop_out);
      end else begin
         pop_out = LNK.fetch_strobe && !mem_empty && go;
         mem_rd = pop_out;
      end
   end

   assign st_v_next = mem_rd || (LOOKAHEAD && st_v_reg && !pop_out);
   assign cnt_next = cnt_reg + CW'(push) - CW'(mem_rd);
   assign total = cnt_reg + CW'(LOOKAHEAD && st_v_reg);

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rpipe_reg <= '0;
      end else begin
         rpipe_reg <= RST_LAT'({rpipe_reg, LNK.reset_req});
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         dis_reg <= 5'h00;
      end else if (srst && FAMILY == fcq_pkg::FCQ_FAMILY_SECOND) begin
         dis_reg <= DIS_C;
      end else if (dis_reg != 5'h00) begin
         dis_reg <= dis_reg - 5'h01;
      end
   end

   always_ff @(posedge CLK) begin
      if (push) begin
         mem[wptr_reg] <= LNK.wr_data;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else if (srst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + AW'(1);
         end
         if (mem_rd) begin
            rptr_reg <= rptr_reg + AW'(1);
         end
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         st_data_reg <= RST_VAL;
         st_v_reg <= 1'b0;
      end else if (srst) begin
         st_data_reg <= RST_VAL;
         st_v_reg <= 1'b0;
      end else begin
         if (mem_rd) begin
            st_data_reg <= mem[rptr_reg];
         end
         st_v_reg <= st_v_next;
      end
   end

   // A lookahead word just taken is stale in the delayed copy, so the
   // copy is marked invalid for that cycle.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         out_data_reg <= RST_VAL;
         out_v_reg <= 1'b0;
      end else if (srst) begin
         out_data_reg <= RST_VAL;
         out_v_reg <= 1'b0;
      end else begin
         out_data_reg <= st_data_reg;
         out_v_reg <= st_v_reg && !(LOOKAHEAD && pop_out);
      end
   end

   assign LNK.rd_data = EMB_REG ? out_data_reg : st_data_reg;
   assign LNK.rd_valid = EMB_REG ? out_v_reg : st_v_reg;
   assign LNK.full_flag = mem_full;
   assign LNK.empty_flag = (total == CW'(0));
   assign LNK.word_count = total;
   assign LNK.fill_fraction = frac_of(total);
   assign LNK.near_empty_flag = HAS_AE && (total <= CW'(AE_LEVEL));
   assign LNK.near_full_flag = HAS_AF && (total >= CW'(DEPTH - AF_LEVEL));
   assign LNK.wr_ready = !mem_full && go;
   assign LNK.busy_flag = busy;
endmodule
`default_nettype wire

// ### src/fcq_feeder.sv
`default_nettype none
module fcq_feeder #(
   parameter int WIDTH = fcq_pkg::WIDTH_DFLT,
   parameter int DEPTH = fcq_pkg::DEPTH_DFLT,
   parameter int PREC = fcq_pkg::PREC_DFLT,
   parameter bit LOOKAHEAD = 1'b0
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   fcq_link.host LNK
);
   typedef enum {FCQ_IDLE, FCQ_WAIT, FCQ_DONE} fcq_state_type;

   localparam logic [fcq_pkg::GATE_W-1:0] START_C =
      fcq_pkg::GATE_W'(fcq_pkg::START_WAIT_CYC);
   localparam logic [fcq_pkg::GATE_W-1:0] QUIET_C =
      fcq_pkg::GATE_W'(fcq_pkg::QUIET_CYC);
   localparam logic [2:0] HOLD_C = 3'(fcq_pkg::RST_HOLD_CYC);

   fcq_state_type state_reg;
   logic [fcq_pkg::GATE_W-1:0] gate_reg;
   logic [2:0] hold_reg;
   logic en_reg;
   logic [31:0] rdata_reg;
   logic err_reg;
   logic acc;
   logic quiet;
   logic is_data;
   logic rd_ok;
   logic rst_cmd;

   assign acc = PSEL && PENABLE && state_reg == FCQ_IDLE;
   assign is_data = (PADDR == fcq_pkg::DATA_OFS);
   // Strobes stay low through the start wait, the reset pulse, the
   // quiet zone and while the queue reports busy.
   assign quiet = gate_reg == '0 && hold_reg == 3'h0 &&
                  !LNK.busy_flag;
   assign rd_ok = en_reg && !LNK.empty_flag;
   assign rst_cmd = acc && PWRITE && PADDR == fcq_pkg::CTRL_OFS &&
                    PWDATA[fcq_pkg::CTRL_RST_BIT];

   assign LNK.wr_strobe = acc && PWRITE && is_data && quiet &&
                          LNK.wr_ready;
   assign LNK.wr_data = PWDATA[WIDTH-1:0];
   assign LNK.fetch_strobe = acc && !PWRITE && is_data && quiet && rd_ok &&
                             (!LOOKAHEAD || LNK.rd_valid);
   assign LNK.reset_req = (hold_reg != 3'h0);
   assign LNK.enable = en_reg;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         hold_reg <= 3'h0;
         gate_reg <= START_C;
      end else if (rst_cmd) begin
         hold_reg <= HOLD_C;
      end else if (hold_reg != 3'h0) begin
         hold_reg <= hold_reg - 3'h1;
         if (hold_reg == 3'h1) begin
            gate_reg <= QUIET_C;
         end
      end else if (gate_reg != '0) begin
         gate_reg <= gate_reg - fcq_pkg::GATE_W'(1);
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         en_reg <= fcq_pkg::CTRL_EN_RST;
      end else if (acc && PWRITE && PADDR == fcq_pkg::CTRL_OFS) begin
         en_reg <= PWDATA[fcq_pkg::CTRL_EN_BIT];
      end
   end

   // Every answer is registered, so a transfer takes two access cycles
   // at the least; data stalls hold pready low until the queue can act.
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= FCQ_IDLE;
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            FCQ_IDLE: begin
               err_reg <= 1'b0;
               rdata_reg <= 32'h0000_0000;
               if (acc) begin
                  if (PWRITE) begin
                     if (!is_data) begin
                        err_reg <= PADDR != fcq_pkg::CTRL_OFS;
                        state_reg <= FCQ_DONE;
                     end else if (LNK.wr_strobe) begin
                        state_reg <= FCQ_DONE;
                     end
                  end else begin
                     unique case (PADDR)
                        fcq_pkg::CTRL_OFS: begin
                           rdata_reg <= 32'(en_reg);
                           state_reg <= FCQ_DONE;
                        end
                        fcq_pkg::STATUS_OFS: begin
                           rdata_reg <= 32'({!quiet, LNK.busy_flag,
                              LNK.near_full_flag, LNK.near_empty_flag,
                              LNK.empty_flag, LNK.full_flag});
                           state_reg <= FCQ_DONE;
                        end
                        fcq_pkg::COUNT_OFS: begin
                           rdata_reg <= 32'(LNK.word_count);
                           state_reg <= FCQ_DONE;
                        end
                        fcq_pkg::FILL_OFS: begin
                           rdata_reg <= 32'(LNK.fill_fraction);
                           state_reg <= FCQ_DONE;
                        end
                        fcq_pkg::DATA_OFS: begin
                           if (!rd_ok) begin
                              err_reg <= 1'b1;
                              state_reg <= FCQ_DONE;
                           end else if (LNK.fetch_strobe) begin
                              if (LOOKAHEAD) begin
                                 rdata_reg <= 32'(LNK.rd_data);
                                 state_reg <= FCQ_DONE;
                              end else begin
                                 state_reg <= FCQ_WAIT;
                              end
                           end
                        end
                        default: begin
                           err_reg <= 1'b1;
                           state_reg <= FCQ_DONE;
                        end
                     endcase
                  end
               end
            end
            FCQ_WAIT: begin
               if (LNK.rd_valid) begin
                  rdata_reg <= 32'(LNK.rd_data);
                  state_reg <= FCQ_DONE;
               end
            end
            FCQ_DONE: begin
               state_reg <= FCQ_IDLE;
            end
         endcase
      end
   end

   assign PREADY = (state_reg == FCQ_DONE);
   assign PRDATA = rdata_reg;
   assign PSLVERR = PREADY && err_reg;
endmodule
`default_nettype wire

// ### tb/fcq_asserts.sv
`default_nettype none
module fcq_asserts #(
   parameter int DEPTH = fcq_pkg::DEPTH_DFLT,
   parameter int PREC = fcq_pkg::PREC_DFLT,
   parameter int AE_LEVEL = fcq_pkg::AE_LEVEL_DFLT,
   parameter int AF_LEVEL = fcq_pkg::AF_LEVEL_DFLT
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic wr_strobe,
   input wire logic wr_ready,
   input wire logic fetch_strobe,
   input wire logic rd_valid,
   input wire logic full_flag,
   input wire logic empty_flag,
   input wire logic near_empty_flag,
   input wire logic near_full_flag,
   input wire logic [PREC-1:0] fill_fraction,
   input wire logic [$clog2(DEPTH)+1:0] word_count,
   input wire logic reset_req,
   input wire logic enable,
   input wire logic busy_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CW = $clog2(DEPTH) + 2;
   logic take_rd;
   int fill_int;
   logic [PREC-1:0] fill_exp;
   assign take_rd = fetch_strobe && !empty_flag && enable && !busy_flag;
   assign fill_int = (int'(word_count) * (2 ** PREC)) / DEPTH;
   assign fill_exp = (fill_int > (2 ** PREC) - 1) ? '1 : PREC'(fill_int);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   a_full_at_depth: assert property (
      full_flag == (word_count == CW'(DEPTH)))
      else $error("full flag disagrees with count");
   a_empty_at_zero: assert property (
      empty_flag == (word_count == '0))
      else $error("empty flag disagrees with count");
   // The reset command clears the store, so counting is not judged then.
   a_write_counts: assert property (
      disable iff (!NRST || reset_req)
      wr_strobe && wr_ready && !fetch_strobe
      |=> word_count == CW'($past(word_count) + 1'b1))
      else $error("accepted write not counted");
   a_read_counts: assert property (
      disable iff (!NRST || reset_req)
      take_rd && !wr_strobe |=> word_count == CW'($past(word_count) - 1'b1))
      else $error("taken read not counted");
   a_full_refuses: assert property (
      full_flag && !take_rd |=> word_count <= $past(word_count))
      else $error("write accepted while full");
   a_read_answers: assert property (
      disable iff (!NRST || reset_req) take_rd |=> rd_valid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (
      rd_valid |-> $past(take_rd))
      else $error("output valid without a read");
   a_fill_value: assert property (
      fill_fraction == fill_exp)
      else $error("fill fraction wrong");
   a_near_levels: assert property (
      near_empty_flag == (word_count <= CW'(AE_LEVEL)) &&
      near_full_flag == (word_count >= CW'(DEPTH - AF_LEVEL)))
      else $error("near flags wrong");
   a_reset_clears: assert property (
      reset_req |-> ##3 word_count == '0)
      else $error("reset command did not clear");
   a_quiet_after: assert property (
      $fell(reset_req) |-> (!wr_strobe && !fetch_strobe) [*8])
      else $error("strobe too soon after reset");
   c_full: cover property (full_flag);
   c_read: cover property (rd_valid);
   c_reset: cover property ($fell(reset_req));
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 16;
   localparam int D = 16;
   localparam int P = 4;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, er;
   logic [15:0] lf;
   int bad_count, tests_run;
   int q[$];
   fcq_link #(.WIDTH(W), .DEPTH(D), .PREC(P)) lnk ();
   fcq_queue #(.WIDTH(W), .DEPTH(D), .PREC(P)) u_fcq_queue (
      .CLK(clk), .NRST(nrst), .LNK(lnk));
   fcq_feeder #(.WIDTH(W), .DEPTH(D), .PREC(P)) u_fcq_feeder (
      .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .LNK(lnk));
   fcq_asserts #(.DEPTH(D), .PREC(P)) u_fcq_asserts (
      .CLK(clk), .NRST(nrst), .wr_strobe(lnk.wr_strobe),
      .wr_ready(lnk.wr_ready), .fetch_strobe(lnk.fetch_strobe),
      .rd_valid(lnk.rd_valid), .full_flag(lnk.full_flag),
      .empty_flag(lnk.empty_flag), .near_empty_flag(lnk.near_empty_flag),
      .near_full_flag(lnk.near_full_flag),
      .fill_fraction(lnk.fill_fraction), .word_count(lnk.word_count),
      .reset_req(lnk.reset_req), .enable(lnk.enable),
      .busy_flag(lnk.busy_flag));

   always #10 clk = ~clk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // The answer is taken at the edge itself, before that edge's updates
   // land, so read data and ready belong to the same sampled cycle.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      er = 32'(pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check_state;
      int n;
      int f;
      logic [3:0] s;
      n = q.size();
      f = n * (2 ** P) / D;
      if (f > (2 ** P) - 1) f = (2 ** P) - 1;
      apb(1'b0, fcq_pkg::COUNT_OFS, 32'h0);
      chk("count", n, rd);
      apb(1'b0, fcq_pkg::FILL_OFS, 32'h0);
      chk("fill", f, rd);
      apb(1'b0, fcq_pkg::STATUS_OFS, 32'h0);
      s = {n >= D - 4, n <= 4, n == 0, n == D};
      chk("status", 32'(s), rd & 32'hf);
   endtask

   task automatic complete_run;
      if (bad_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lf = 16'h0021;
      bad_count = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, fcq_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, fcq_pkg::DATA_OFS, 32'h0);
      chk("error", 32'h1, er);
      apb(1'b1, fcq_pkg::CTRL_OFS, 32'h1);
      check_state;
      for (int i = 0; i < D; i++) begin
         lf = lfsr_next(lf);
         apb(1'b1, fcq_pkg::DATA_OFS, {16'h0, lf});
         q.push_back(lf);
         check_state;
      end
      for (int i = 0; i < D; i++) begin
         apb(1'b0, fcq_pkg::DATA_OFS, 32'h0);
         chk("data", q.pop_front(), rd);
         chk("error", 32'h0, er);
         check_state;
      end
      apb(1'b0, fcq_pkg::DATA_OFS, 32'h0);
      chk("error", 32'h1, er);
      chk("data", 32'h0, rd);
      apb(1'b0, 8'h20, 32'h0);
      chk("error", 32'h1, er);
      for (int i = 0; i < 2; i++) begin
         lf = lfsr_next(lf);
         apb(1'b1, fcq_pkg::DATA_OFS, {16'h0, lf});
      end
      // The reset command drops the stored words; the next data write stalls.
      apb(1'b1, fcq_pkg::CTRL_OFS, 32'h3);
      apb(1'b0, fcq_pkg::STATUS_OFS, 32'h0);
      chk("busy", 32'h3, (rd >> 4) & 32'h3);
      q.delete();
      apb(1'b1, fcq_pkg::CTRL_OFS, 32'h1);
      lf = lfsr_next(lf);
      apb(1'b1, fcq_pkg::DATA_OFS, {16'h0, lf});
      q.push_back(lf);
      check_state;
      apb(1'b0, fcq_pkg::DATA_OFS, 32'h0);
      chk("data", q.pop_front(), rd);
      complete_run;
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run;
   end
endmodule
`default_nettype wire
